/* File: logic/eth_tx_pkg.sv */
// Purpose: Shared constants and types of the transmit status block.
// Assumes: 250 MHz system clock, 32-bit AHB-Lite register access.
// Notes: Register offsets are byte addresses inside the block window.
package eth_tx_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int BYTE_TIME_NS = 80;
  localparam int BYTE_CYCLES = (BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] BYTE_DIV_LAST = 5'(BYTE_CYCLES - 1);

  // ==========================================================
  // Register map
  localparam logic [11:0] TX_STATUS_OFFSET = 12'h000;
  localparam logic [11:0] GEN_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h008;
  localparam logic [11:0] MAC_CONFIG_OFFSET = 12'h00C;

  // Transmit completion status fields
  localparam int TXS_SUCCESS_BIT = 15;
  localparam int TXS_UNDERRUN_BIT = 9;
  localparam int TXS_OVERSIZE_BIT = 8;
  localparam int TXS_DEFERRED_BIT = 6;
  localparam int TXS_CRC_BIT = 5;
  localparam logic [15:0] TX_STATUS_RESET = 16'h0000;

  // General status and mask fields
  localparam int GEN_BUF_COMPLETE_BIT = 0;
  localparam int GEN_REG_EMPTY_BIT = 1;
  localparam int GEN_FIFO_ROOM_BIT = 2;
  localparam logic [2:0] GEN_STATUS_RESET = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // MAC configuration fields
  localparam int CFG_CRC_APPEND_BIT = 0;
  localparam int CFG_OVERSIZE_ALLOW_BIT = 1;
  localparam logic [1:0] MAC_CONFIG_RESET = 2'h1;

  // ==========================================================
  // Frame limits and CRC
  localparam logic [10:0] MAX_FRAME_BYTES = 11'd1518;
  localparam logic [10:0] FCS_BYTES = 11'd4;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEFER, ST_SEND, ST_FCS, ST_END, ST_FLUSH, ST_RELEASE
  } tx_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } src_byte_type;

  typedef struct packed {
    logic tx_en;
    logic [7:0] txd;
  } phy_out_type;

endpackage

/* File: logic/crc32_step.sv */
// Purpose: One byte step of the reflected Ethernet CRC-32.
// Assumes: Byte is fed least significant bit first, as on the wire.
// Notes: Purely combinational; the caller holds the running value.
`timescale 1ns/1ns
module crc32_step (
  input wire logic [31:0] crc_in, // Running CRC before the byte
  input wire logic [7:0] data, // Byte to fold in
  output logic [31:0] crc_out // Running CRC after the byte
);

  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ eth_tx_pkg::CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end

endmodule

/* File: logic/eth_tx_status.sv */
// Purpose: Transmit engine status reporting, abort flushing and retry of an Ethernet MAC.
// Assumes: Frame source holds each byte until taken and can rewind to frame start.
// Notes: Registers sit on AHB-Lite with zero wait states.
`timescale 1ns/1ns
module eth_tx_status (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic [31:0] hrdata, // Read data
  input wire eth_tx_pkg::src_byte_type src, // Frame byte from transmit FIFO
  output logic src_take, // Pulse: byte of previous cycle taken
  output logic src_rewind, // Pulse: restart frame from first byte
  input wire logic fifo_can_accept, // FIFO ready for the next frame
  input wire logic carrier_sense, // Medium busy
  output eth_tx_pkg::phy_out_type phy, // Transmit data to PHY
  input wire logic dma_mode, // Descriptor mode enabled
  output logic [15:0] desc_status, // Status for the buffer descriptor
  output logic desc_write, // Pulse: write desc_status
  output logic irq // Level interrupt
);

  // ==========================================================
  // State
  typedef struct packed {
    eth_tx_pkg::tx_state_type state;
    logic [4:0] div;
    logic tick;
    logic [10:0] count;
    logic [1:0] fcs_idx;
    logic [31:0] crc;
    logic first_try;
    logic deferred;
    logic crc_bad;
    logic [15:0] tx_status;
    logic [2:0] gen_status;
    logic [2:0] irq_mask;
    logic [1:0] mac_config;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    eth_tx_pkg::phy_out_type phy;
    logic src_take;
    logic src_rewind;
    logic [15:0] desc_status;
    logic desc_write;
  } core_type;

  core_type cur;
  core_type next_cur;
  logic [31:0] crc_next;

  crc32_step crc_unit (
    .crc_in(cur.crc),
    .data(src.data),
    .crc_out(crc_next)
  );

  always_comb begin
    logic [2:0] gen_set;
    logic [2:0] gen_clr;
    logic [10:0] limit;
    logic addr_ok;
    logic crc_append;
    next_cur = cur;
    gen_set = 3'h0;
    gen_clr = 3'h0;
    crc_append = cur.mac_config[eth_tx_pkg::CFG_CRC_APPEND_BIT];
    limit = crc_append ? eth_tx_pkg::MAX_FRAME_BYTES - eth_tx_pkg::FCS_BYTES
                       : eth_tx_pkg::MAX_FRAME_BYTES;
    addr_ok = (haddr[31:12] == 20'h00000);
    next_cur.src_take = 1'b0;
    next_cur.src_rewind = 1'b0;
    next_cur.desc_write = 1'b0;

    // ==========================================================
    // Byte rate divider
    if (cur.div == eth_tx_pkg::BYTE_DIV_LAST) begin
      next_cur.div = 5'h00;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.div = cur.div + 5'h01;
      next_cur.tick = 1'b0;
    end

    // ==========================================================
    // Transmit sequence
    unique case (cur.state)
      eth_tx_pkg::ST_IDLE: begin
        if (src.valid) begin
          next_cur.first_try = 1'b1;
          next_cur.deferred = 1'b0;
          next_cur.count = 11'd0;
          next_cur.crc = eth_tx_pkg::CRC_INIT;
          next_cur.state = eth_tx_pkg::ST_DEFER;
        end
      end
      eth_tx_pkg::ST_DEFER: begin
        if (cur.tick) begin
          if (carrier_sense) begin
            // Only the opening attempt may mark the frame as deferred
            if (cur.first_try && !cur.deferred) begin
              next_cur.deferred = 1'b1;
              next_cur.tx_status = 16'h0000;
              next_cur.tx_status[eth_tx_pkg::TXS_DEFERRED_BIT] = 1'b1;
            end
          end else begin
            next_cur.first_try = 1'b0;
            next_cur.state = eth_tx_pkg::ST_SEND;
          end
        end
      end
      eth_tx_pkg::ST_SEND: begin
        if (cur.tick) begin
          if (!src.valid) begin
            // Source fell behind the line: cut the frame short
            next_cur.phy.tx_en = 1'b0;
            next_cur.tx_status = 16'h0000;
            next_cur.tx_status[eth_tx_pkg::TXS_UNDERRUN_BIT] = 1'b1;
            gen_set[eth_tx_pkg::GEN_BUF_COMPLETE_BIT] = 1'b1;
            next_cur.desc_status = next_cur.tx_status;
            next_cur.desc_write = dma_mode;
            next_cur.state = eth_tx_pkg::ST_FLUSH;
          end else if (cur.count == limit
                       && !cur.mac_config[eth_tx_pkg::CFG_OVERSIZE_ALLOW_BIT]) begin
            next_cur.phy.tx_en = 1'b0;
            next_cur.src_take = 1'b1;
            next_cur.tx_status = 16'h0000;
            next_cur.tx_status[eth_tx_pkg::TXS_OVERSIZE_BIT] = 1'b1;
            gen_set[eth_tx_pkg::GEN_BUF_COMPLETE_BIT] = 1'b1;
            next_cur.desc_status = next_cur.tx_status;
            next_cur.desc_write = dma_mode;
            next_cur.state = src.last ? eth_tx_pkg::ST_RELEASE
                                      : eth_tx_pkg::ST_FLUSH;
          end else begin
            next_cur.phy.tx_en = 1'b1;
            next_cur.phy.txd = src.data;
            next_cur.src_take = 1'b1;
            next_cur.crc = crc_next;
            next_cur.count = cur.count + 11'd1;
            if (src.last) begin
              // Without append the last four bytes are the supplied FCS
              next_cur.crc_bad = !crc_append && (crc_next != eth_tx_pkg::CRC_RESIDUE);
              next_cur.fcs_idx = 2'h0;
              next_cur.state = crc_append ? eth_tx_pkg::ST_FCS : eth_tx_pkg::ST_END;
            end
          end
        end
      end
      eth_tx_pkg::ST_FCS: begin
        if (cur.tick) begin
          next_cur.phy.txd = ~cur.crc[8 * cur.fcs_idx +: 8];
          next_cur.fcs_idx = cur.fcs_idx + 2'h1;
          if (cur.fcs_idx == 2'h3) begin
            next_cur.state = eth_tx_pkg::ST_END;
          end
        end
      end
      eth_tx_pkg::ST_END: begin
        if (cur.tick) begin
          next_cur.phy.tx_en = 1'b0;
          next_cur.tx_status = 16'h0000;
          next_cur.tx_status[eth_tx_pkg::TXS_DEFERRED_BIT] = cur.deferred;
          if (cur.crc_bad) begin
            // Retry silently; software sees it only by polling
            next_cur.tx_status[eth_tx_pkg::TXS_CRC_BIT] = 1'b1;
            next_cur.count = 11'd0;
            next_cur.crc = eth_tx_pkg::CRC_INIT;
            next_cur.crc_bad = 1'b0;
            next_cur.src_rewind = 1'b1;
            next_cur.state = eth_tx_pkg::ST_DEFER;
          end else begin
            next_cur.tx_status[eth_tx_pkg::TXS_SUCCESS_BIT] = 1'b1;
            gen_set[eth_tx_pkg::GEN_BUF_COMPLETE_BIT] = 1'b1;
            next_cur.desc_status = next_cur.tx_status;
            next_cur.desc_write = dma_mode;
            next_cur.state = eth_tx_pkg::ST_RELEASE;
          end
        end
      end
      eth_tx_pkg::ST_FLUSH: begin
        // Drain at line rate so the FIFO sees the same pacing
        if (cur.tick && src.valid) begin
          next_cur.src_take = 1'b1;
          if (src.last) begin
            next_cur.state = eth_tx_pkg::ST_RELEASE;
          end
        end
      end
      eth_tx_pkg::ST_RELEASE: begin
        if (fifo_can_accept && !cur.src_take) begin
          gen_set[eth_tx_pkg::GEN_REG_EMPTY_BIT] = 1'b1;
          gen_set[eth_tx_pkg::GEN_FIFO_ROOM_BIT] = 1'b1;
          next_cur.state = eth_tx_pkg::ST_IDLE;
        end
      end
      // Spare code of the state encoding falls back to idle
      default: begin
        next_cur.state = eth_tx_pkg::ST_IDLE;
      end
    endcase

    // ==========================================================
    // AHB-Lite slave, zero wait states
    // No wait states and no error response, so both stand fixed
    next_cur.hreadyout = 1'b1;
    next_cur.hresp = 1'b0;
    next_cur.wr_pend = 1'b0;
    if (cur.wr_pend) begin
      unique case (cur.wr_addr)
        eth_tx_pkg::GEN_STATUS_OFFSET: gen_clr = hwdata[2:0];
        eth_tx_pkg::IRQ_MASK_OFFSET: next_cur.irq_mask = hwdata[2:0];
        eth_tx_pkg::MAC_CONFIG_OFFSET: next_cur.mac_config = hwdata[1:0];
        default: begin
        end
      endcase
    end
    if (hsel && hready && htrans == eth_tx_pkg::HTRANS_NONSEQ) begin
      next_cur.hrdata = 32'h00000000;
      if (hwrite) begin
        next_cur.wr_pend = addr_ok;
        next_cur.wr_addr = haddr[11:0];
      end else if (addr_ok) begin
        unique case (haddr[11:0])
          eth_tx_pkg::TX_STATUS_OFFSET: next_cur.hrdata = {16'h0000, cur.tx_status};
          eth_tx_pkg::GEN_STATUS_OFFSET: next_cur.hrdata = {29'h0, cur.gen_status};
          eth_tx_pkg::IRQ_MASK_OFFSET: next_cur.hrdata = {29'h0, cur.irq_mask};
          eth_tx_pkg::MAC_CONFIG_OFFSET: next_cur.hrdata = {30'h0, cur.mac_config};
          default: next_cur.hrdata = 32'h00000000;
        endcase
      end
    end

    // Reserved and unused positions are never loaded
    next_cur.tx_status[7] = 1'b0;
    next_cur.tx_status[4] = 1'b0;
    next_cur.desc_status[7] = 1'b0;
    next_cur.desc_status[4] = 1'b0;

    // ==========================================================
    // Sticky flags: a set in the clearing cycle survives
    next_cur.gen_status = (cur.gen_status & ~gen_clr) | gen_set;
    next_cur.irq = |(next_cur.gen_status & next_cur.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '{
        state: eth_tx_pkg::ST_IDLE,
        crc: eth_tx_pkg::CRC_INIT,
        tx_status: eth_tx_pkg::TX_STATUS_RESET,
        gen_status: eth_tx_pkg::GEN_STATUS_RESET,
        irq_mask: eth_tx_pkg::IRQ_MASK_RESET,
        mac_config: eth_tx_pkg::MAC_CONFIG_RESET,
        hreadyout: 1'b1,
        default: '0
      };
    end else begin
      cur <= next_cur;
    end
  end

  assign hreadyout = cur.hreadyout;
  assign hresp = cur.hresp;
  assign hrdata = cur.hrdata;
  assign src_take = cur.src_take;
  assign src_rewind = cur.src_rewind;
  assign phy = cur.phy;
  assign desc_status = cur.desc_status;
  assign desc_write = cur.desc_write;
  assign irq = cur.irq;

endmodule

/* File: verif/eth_tx_status_properties.sv */
// Purpose: Concurrent checks on the ports of the transmit status block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Attached to every instance of the block by the bind at the foot.
`timescale 1ns/1ns
module eth_tx_status_checker (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Reset, active low
  input wire eth_tx_pkg::src_byte_type src, // Byte offered by the source
  input wire logic src_take, // Byte taken
  input wire logic src_rewind, // Frame restart
  input wire eth_tx_pkg::phy_out_type phy, // Wire side
  input wire logic dma_mode, // Descriptor mode
  input wire logic [15:0] desc_status, // Descriptor status
  input wire logic desc_write // Descriptor strobe
);
  default clocking main_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // Completion outcome
  chk_desc_mode: assert property (desc_write |-> dma_mode)
    else $error("descriptor written outside dma mode");
  chk_unused_zero: assert property (desc_write |-> desc_status[7] == 1'b0 && !desc_status[4])
    else $error("unused status bit set");
  chk_success_alone: assert property (desc_write && desc_status[15] |->
    desc_status[9:8] == 2'b00 && !desc_status[5])
    else $error("success mixed with error");
  chk_underrun_alone: assert property (desc_write && desc_status[9] |->
    !desc_status[15] && !desc_status[8])
    else $error("underrun mixed with other outcome");
  chk_oversize_alone: assert property (desc_write && desc_status[8] |->
    !desc_status[15] && !desc_status[9])
    else $error("oversize mixed with other outcome");

  // ==========================================================
  // Flush and retry
  // The rest of an aborted frame is flushed, so the wire must stay idle for eight cycles after the abort
  chk_flush_quiet: assert property (desc_write && (desc_status[9] || desc_status[8]) |=>
    !phy.tx_en [*8])
    else $error("wire driven after abort");
  chk_take_valid: assert property (src_take |-> $past(src.valid) && !$past(src_take))
    else $error("byte taken that was not offered");
  chk_rewind_quiet: assert property (src_rewind |-> !desc_write ##1 !src_rewind)
    else $error("crc retry raised a completion");
endmodule

bind eth_tx_status eth_tx_status_checker CHECK (.hclk(hclk), .hresetn(hresetn), .src(src),
  .src_take(src_take), .src_rewind(src_rewind), .phy(phy), .dma_mode(dma_mode),
  .desc_status(desc_status), .desc_write(desc_write));

/* File: verif/phy_medium_model.sv */
// Purpose: Medium and PHY side of the transmit path.
// Assumes: Carrier sense follows the bench's busy request directly.
// Notes: Counts clocks with transmit enable high, twenty per byte on the wire.
`timescale 1ns/1ns
module phy_medium_model (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Reset, active low
  input wire eth_tx_pkg::phy_out_type phy, // Transmit data from the MAC
  input wire logic busy, // Medium held by another station
  output logic carrier_sense, // Medium busy as seen by the MAC
  output logic [31:0] on_cycles, // Clocks spent sending bytes
  output logic [7:0] last_byte // Last byte put on the wire
);
  // ==========================================================
  // Medium
  assign carrier_sense = busy;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_cycles <= 32'h0;
      last_byte <= 8'h00;
    end else if (phy.tx_en) begin
      on_cycles <= on_cycles + 32'h1;
      last_byte <= phy.txd;
    end
  end
endmodule

/* File: verif/test_eth_tx_status.sv */
// Purpose: Self-checking bench for the transmit status block.
// Assumes: One AHB-Lite master; the frame source is modelled here.
// Notes: Long frames run at the real byte rate, some 65k cycles in all.
`timescale 1ns/1ns
module test_eth_tx_status;
  // ==========================================================
  // Signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic fifo_ok = 1'b1;
  logic busy = 1'b0;
  logic dry = 1'b0;
  logic go = 1'b0;
  logic dma = 1'b1;
  logic good = 1'b0;
  logic [31:0] fcs = 32'h0;
  logic [31:0] fcs_sel;
  logic [7:0] last_byte;
  int writes = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [10:0] cnt = 11'h0;
  logic [10:0] len = 11'h0;
  logic hreadyout, hresp, src_take, src_rewind, desc_write, irq, carrier;
  logic [31:0] hrdata, rd, on_cycles, base;
  logic [15:0] desc_status;
  eth_tx_pkg::src_byte_type src;
  eth_tx_pkg::phy_out_type phy;
  int bad_count = 0;
  int checked = 0;

  // ==========================================================
  // Design, medium and frame source
  eth_tx_status DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src(src), .src_take(src_take),
    .src_rewind(src_rewind), .fifo_can_accept(fifo_ok), .carrier_sense(carrier), .phy(phy),
    .dma_mode(dma), .desc_status(desc_status), .desc_write(desc_write), .irq(irq));
  phy_medium_model MEDIUM (.hclk(hclk), .hresetn(hresetn), .phy(phy), .busy(busy),
    .carrier_sense(carrier), .on_cycles(on_cycles), .last_byte(last_byte));
  // Byte stands until taken; dry starves the source to force an underrun
  // With good set the last four bytes carry a correct check sequence
  assign fcs_sel = fcs >> {2'(cnt - len), 3'h0};
  assign src = '{data: (good && cnt >= len - 11'h4) ? fcs_sel[7:0] : cnt[7:0] ^ 8'h5A,
    valid: (cnt < len) && !dry, last: cnt == len - 11'h1};
  always @(posedge hclk) begin
    if (desc_write) begin
      writes <= writes + 1;
    end
    if (go || src_rewind) begin
      cnt <= 11'h0;
    end else if (src_take) begin
      cnt <= cnt + 11'h1;
    end
  end
  initial begin
    forever #2 hclk = ~hclk;
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= eth_tx_pkg::HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic reg_is(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check($sformatf("register %h", a), rd, e);
    check("response", hresp, 32'h0);
  endtask
  function automatic logic [31:0] fcs_of(input logic [10:0] n);
    logic [31:0] c;
    logic [7:0] d;
    c = eth_tx_pkg::CRC_INIT;
    for (int k = 0; k < n; k++) begin
      d = 8'(k) ^ 8'h5A;
      for (int b = 0; b < 8; b++) begin
        c = (c[0] ^ d[b]) ? (c >> 1) ^ eth_tx_pkg::CRC_POLY : c >> 1;
      end
    end
    return ~c;
  endfunction
  task automatic wait_ev(input logic rewind, input int lim);
    int n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while ((rewind ? src_rewind : desc_write) !== 1'b1 && n < lim);
    check("event wait", n < lim, 32'h1);
    // Back onto the rising edge so callers drive inputs there
    @(posedge hclk);
  endtask
  task automatic send(input logic [10:0] n);
    base = on_cycles;
    @(posedge hclk);
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    len <= n;
  endtask
  task automatic clear();
    repeat (200) @(posedge hclk);
    bus(1'b1, eth_tx_pkg::GEN_STATUS_OFFSET, 32'h7);
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    reg_is(eth_tx_pkg::TX_STATUS_OFFSET, 32'h0);
    reg_is(eth_tx_pkg::MAC_CONFIG_OFFSET, 32'h1);
    reg_is(12'h010, 32'h0);
    bus(1'b1, eth_tx_pkg::TX_STATUS_OFFSET, 32'hFFFFFFFF);
    reg_is(eth_tx_pkg::TX_STATUS_OFFSET, 32'h0);
  endtask
  task automatic t_defer();
    bus(1'b1, eth_tx_pkg::IRQ_MASK_OFFSET, 32'h1);
    busy <= 1'b1;
    send(11'h006);
    repeat (100) @(posedge hclk);
    reg_is(eth_tx_pkg::TX_STATUS_OFFSET, 32'h40);
    busy <= 1'b0;
    wait_ev(1'b0, 2000);
    check("deferred outcome", desc_status, 32'h8040);
    check("bytes with fcs", on_cycles - base, 32'hC8);
    repeat (20) @(posedge hclk);
    reg_is(eth_tx_pkg::GEN_STATUS_OFFSET, 32'h7);
    check("irq raised", irq, 32'h1);
    clear();
    repeat (2) @(negedge hclk);
    check("irq cleared", irq, 32'h0);
  endtask
  task automatic t_underrun();
    fifo_ok <= 1'b0;
    send(11'h028);
    repeat (200) @(posedge hclk);
    dry <= 1'b1;
    wait_ev(1'b0, 200);
    check("underrun outcome", desc_status, 32'h200);
    dry <= 1'b0;
    repeat (1000) @(posedge hclk);
    reg_is(eth_tx_pkg::GEN_STATUS_OFFSET, 32'h1);
    check("frame drained", cnt, len);
    fifo_ok <= 1'b1;
    repeat (4) @(posedge hclk);
    reg_is(eth_tx_pkg::GEN_STATUS_OFFSET, 32'h7);
    clear();
  endtask
  task automatic t_oversize();
    // 1515 bytes plus appended check sequence is one byte over the limit
    send(11'h5EB);
    wait_ev(1'b0, 31000);
    check("oversize outcome", desc_status, 32'h100);
    repeat (200) @(posedge hclk);
    reg_is(eth_tx_pkg::GEN_STATUS_OFFSET, 32'h7);
    clear();
    bus(1'b1, eth_tx_pkg::MAC_CONFIG_OFFSET, 32'h3);
    send(11'h5EB);
    wait_ev(1'b0, 31000);
    check("oversize allowed", desc_status, 32'h8000);
    check("oversize bytes", on_cycles - base, 32'h76AC);
    clear();
  endtask
  task automatic t_crc();
    bus(1'b1, eth_tx_pkg::MAC_CONFIG_OFFSET, 32'h0);
    send(11'h006);
    wait_ev(1'b1, 400);
    check("bytes without fcs", on_cycles - base, 32'h78);
    check("last source byte", last_byte, 32'h5F);
    reg_is(eth_tx_pkg::TX_STATUS_OFFSET, 32'h20);
    reg_is(eth_tx_pkg::GEN_STATUS_OFFSET, 32'h0);
    wait_ev(1'b1, 400);
    dry <= 1'b1;
    wait_ev(1'b0, 200);
    check("abort ends retry", desc_status, 32'h200);
    dry <= 1'b0;
    clear();
  endtask
  task automatic t_good_fcs();
    int w;
    w = writes;
    dma <= 1'b0;
    good <= 1'b1;
    fcs <= fcs_of(11'h006);
    send(11'h00A);
    repeat (400) @(posedge hclk);
    reg_is(eth_tx_pkg::TX_STATUS_OFFSET, 32'h8000);
    check("supplied fcs bytes", on_cycles - base, 32'hC8);
    check("supplied fcs on wire", last_byte, fcs[31:24]);
    check("no descriptor write", writes - w, 32'h0);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_defer();
    t_underrun();
    t_oversize();
    t_crc();
    t_good_fcs();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge hclk);
    bad_count++;
    stop_test();
  end
endmodule
